// *** design/iox_defines.svh ***
// Purpose: Constants for the increment and OR execution block
// Assumes: 14-bit instruction word, 7-bit file address
// Notes:   Included by bare name
`ifndef IOX_DEFINES_SVH
`define IOX_DEFINES_SVH

// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define IOX_OPC_INC_FILE     6'h0A
`define IOX_OPC_INC_SKIP     6'h0F
`define IOX_OPC_OR_FILE      6'h04
`define IOX_OPC_OR_LIT       6'h38
`define IOX_OPC_HI_POS       13
`define IOX_OPC_LO_POS       8
`define IOX_DEST_POS         7

// ----------------------------------------
// Phase and reset values
// ----------------------------------------
`define IOX_PHASES           4
`define IOX_ACC_RESET        8'h00
`define IOX_ZERO_RESET       1'b0
`define IOX_NOP_WORD         14'h0000

`endif

// *** design/iox_pkg.sv ***
// Purpose: Types for the increment and OR execution block
// Assumes: Nothing beyond the defines header
// Notes:   Types only
package iox_pkg;

    // ----------------------------------------
    // Phase and operation types
    // ----------------------------------------
    typedef enum logic [1:0] {
        IOX_Q1,
        IOX_Q2,
        IOX_Q3,
        IOX_Q4
    } iox_phase_e;

    typedef enum logic [2:0] {
        IOX_OP_NONE,
        IOX_OP_INC_FILE,
        IOX_OP_INC_SKIP,
        IOX_OP_OR_LIT,
        IOX_OP_OR_FILE
    } iox_op_e;

    // Decoded instruction fields
    typedef struct packed {
        iox_op_e    op;
        logic       dest_file;
        logic [6:0] file_addr;
        logic [7:0] literal;
    } iox_decode_s;

    // Register file write request
    typedef struct packed {
        logic       wr_en;
        logic [6:0] addr;
        logic [7:0] data;
    } iox_file_wr_s;

endpackage : iox_pkg

// *** design/iox_decode.sv ***
// Purpose: Combinational opcode decode for the execution block
// Assumes: Instruction word stable while decoded
// Notes:   Unknown opcodes decode as no operation
`timescale 1ns/10ps
`include "iox_defines.svh"

module iox_decode (
    input  wire logic [13:0]         instr,
    output iox_pkg::iox_decode_s     dec
);

    // ----------------------------------------
    // Opcode match
    // ----------------------------------------
    wire logic [5:0] opc_field = instr[`IOX_OPC_HI_POS:`IOX_OPC_LO_POS];
    wire logic       is_inc    = (opc_field == `IOX_OPC_INC_FILE);
    wire logic       is_skip   = (opc_field == `IOX_OPC_INC_SKIP);
    wire logic       is_orf    = (opc_field == `IOX_OPC_OR_FILE);
    wire logic       is_orl    = (opc_field == `IOX_OPC_OR_LIT);

    // Select operation, then pack it with the operand fields through one driver
    wire iox_pkg::iox_op_e op_sel = is_inc  ? iox_pkg::IOX_OP_INC_FILE :
                                    is_skip ? iox_pkg::IOX_OP_INC_SKIP :
                                    is_orf  ? iox_pkg::IOX_OP_OR_FILE  :
                                    is_orl  ? iox_pkg::IOX_OP_OR_LIT   :
                                              iox_pkg::IOX_OP_NONE;
    assign dec = '{op        : op_sel,
                   dest_file : instr[`IOX_DEST_POS],
                   file_addr : instr[6:0],
                   literal   : instr[7:0]};

endmodule // iox_decode

// *** design/iox_exec.sv ***
// Purpose: Executes increment, increment-skip and the two OR instructions
// Assumes: File register read data is valid in Q2 for the address shown
// Notes:   One instruction cycle is four clocks, Q1 to Q4
//
// Overview of operation
// - Plain increment reads addressed register, adds one, sets zero flag on zero.
// - Destination bit clear: result goes to accumulator, register left unchanged.
// - Destination bit set: result written back to the same register.
// - Increment-skip increments, routes by destination bit, flags untouched.
// - Increment-skip with nonzero result takes one cycle, next runs normally.
// - Increment-skip with zero result replaces next instruction by no-operation.
// - Each cycle: Q1 decode, Q2 read, Q3 process, Q4 write.
`timescale 1ns/10ps
`include "iox_defines.svh"

module iox_exec (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [13:0]         instr,
    input  wire logic [7:0]          file_rd_data,
    output iox_pkg::iox_phase_e      phase,
    output logic [6:0]               file_rd_addr,
    output iox_pkg::iox_file_wr_s    file_wr,
    output logic [7:0]               acc,
    output logic                     zero_flag,
    output logic                     skip_active,
    output logic                     instr_done
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    iox_pkg::iox_phase_e   phase_reg;
    iox_pkg::iox_phase_e   phase_next;
    iox_pkg::iox_decode_s  dec_raw;
    iox_pkg::iox_decode_s  dec_reg;
    iox_pkg::iox_file_wr_s wr_reg;
    iox_pkg::iox_file_wr_s wr_next;
    logic [7:0]            acc_reg;
    logic [7:0]            acc_next;
    logic                  zero_reg;
    logic                  zero_next;
    logic [7:0]            operand_reg;
    logic [7:0]            result_reg;
    logic                  skip_next;
    logic                  squash_reg;
    logic                  done_reg;
    logic [6:0]            rd_addr_reg;

    // Current word, or a no-operation while a skip squashes it
    wire logic [13:0] eff_instr = squash_reg ? `IOX_NOP_WORD : instr;

    iox_decode u_decode (
        .instr (eff_instr),
        .dec   (dec_raw)
    );

    // ----------------------------------------
    // Phase sequencing
    // ----------------------------------------
    // Four phases per instruction cycle, wrapping Q4 to Q1
    always_comb begin
        unique case (phase_reg)
            iox_pkg::IOX_Q1: phase_next = iox_pkg::IOX_Q2;
            iox_pkg::IOX_Q2: phase_next = iox_pkg::IOX_Q3;
            iox_pkg::IOX_Q3: phase_next = iox_pkg::IOX_Q4;
            iox_pkg::IOX_Q4: phase_next = iox_pkg::IOX_Q1;
        endcase
    end

    // Phase register starts every instruction cycle in Q1 after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= iox_pkg::IOX_Q1;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // ----------------------------------------
    // Datapath decode
    // ----------------------------------------
    wire logic q1      = (phase_reg == iox_pkg::IOX_Q1);
    wire logic q2      = (phase_reg == iox_pkg::IOX_Q2);
    wire logic q3      = (phase_reg == iox_pkg::IOX_Q3);
    wire logic q4      = (phase_reg == iox_pkg::IOX_Q4);
    wire logic op_inc  = (dec_reg.op == iox_pkg::IOX_OP_INC_FILE);
    wire logic op_skip = (dec_reg.op == iox_pkg::IOX_OP_INC_SKIP);
    wire logic op_orl  = (dec_reg.op == iox_pkg::IOX_OP_OR_LIT);
    wire logic op_orf  = (dec_reg.op == iox_pkg::IOX_OP_OR_FILE);
    wire logic uses_file = op_inc | op_skip | op_orf;
    wire logic res_zero  = (result_reg == 8'h00);

    // Process step: increment or OR of the latched operand
    wire logic [7:0] calc = (op_inc | op_skip) ? 8'(operand_reg + 8'h01) :
                            (acc_reg | operand_reg);

    // Operand source: the literal for OR-literal, otherwise the register file read port
    wire logic [7:0] operand_sel = op_orl ? dec_reg.literal : file_rd_data;

    // Q1: latch the decoded word; a squashed cycle latches a no-operation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_reg <= '0;
        end else if (q1) begin
            dec_reg <= dec_raw;
        end
    end

    // Q1: present the source address so the register file answers during Q2
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_addr_reg <= 7'h00;
        end else if (q1) begin
            rd_addr_reg <= dec_raw.file_addr;
        end
    end

    // Q2: capture the operand while the read address is settled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            operand_reg <= 8'h00;
        end else if (q2) begin
            operand_reg <= operand_sel;
        end
    end

    // Q3: hold the computed result for the Q4 write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= 8'h00;
        end else if (q3) begin
            result_reg <= calc;
        end
    end

    // ----------------------------------------
    // Destination and flag selection
    // ----------------------------------------
    // File results follow the destination bit; the literal OR always ends in the accumulator
    wire logic to_file  = uses_file & dec_reg.dest_file;
    wire logic to_acc   = (uses_file & ~dec_reg.dest_file) | op_orl;
    // Increment-skip leaves the zero flag alone
    wire logic zero_upd = op_inc | op_orf | op_orl;
    // Only a zero increment-skip result discards the word already fetched
    wire logic skip_hit = op_skip & res_zero;

    // ----------------------------------------
    // Write to destination in Q4
    // ----------------------------------------
    // Next accumulator, flag and write request; only the request's address and data move outside Q4
    always_comb begin
        acc_next     = acc_reg;
        zero_next    = zero_reg;
        wr_next      = '0;
        wr_next.addr = dec_reg.file_addr;
        wr_next.data = result_reg;
        skip_next    = 1'b0;
        if (q4) begin
            wr_next.wr_en = to_file;
            if (to_acc) begin
                acc_next = result_reg;
            end
            if (zero_upd) begin
                zero_next = res_zero;
            end
            skip_next = skip_hit;
        end
    end

    // Accumulator takes a Q4 result only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= `IOX_ACC_RESET;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // Zero flag holds unless a flag-setting instruction reaches Q4
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_reg <= `IOX_ZERO_RESET;
        end else begin
            zero_reg <= zero_next;
        end
    end

    // Write request stands for the one clock after Q4
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
        end else begin
            wr_reg <= wr_next;
        end
    end

    // ----------------------------------------
    // Skip handling
    // ----------------------------------------
    // Squash is set at the end of Q4 and covers the whole next cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            squash_reg <= 1'b0;
        end else if (q4) begin
            squash_reg <= skip_next;
        end
    end

    // Completion pulse in the clock after each Q4
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= q4;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign phase        = phase_reg;
    assign file_rd_addr = rd_addr_reg;
    assign file_wr      = wr_reg;
    assign acc          = acc_reg;
    assign zero_flag    = zero_reg;
    assign skip_active  = squash_reg;
    assign instr_done   = done_reg;

endmodule // iox_exec

// *** dv/iox_exec_assertions.sv ***
// Purpose: Port assertions for iox_exec
// Assumes: Instruction word held for its whole cycle
// Notes:   Bound to every iox_exec instance
`timescale 1ns/10ps
`include "iox_defines.svh"
module iox_exec_assertions (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic [13:0]           instr,
    input wire logic [7:0]            file_rd_data,
    input iox_pkg::iox_phase_e        phase,
    input wire logic [6:0]            file_rd_addr,
    input iox_pkg::iox_file_wr_s      file_wr,
    input wire logic [7:0]            acc,
    input wire logic                  zero_flag,
    input wire logic                  skip_active,
    input wire logic                  instr_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Phase walk and results
    // ----------------------------------------
    sequence q_walk;
        phase == iox_pkg::IOX_Q2 ##1 phase == iox_pkg::IOX_Q3 ##1 phase == iox_pkg::IOX_Q4;
    endsequence
    sequence squash_cycle;
        skip_active [*4] ##1 !skip_active;
    endsequence
    phase_walk_a: assert property (phase == iox_pkg::IOX_Q1 |=> q_walk)
        else $error("phase order broken");
    done_timing_a: assert property (instr_done |-> $past(phase) == iox_pkg::IOX_Q4)
        else $error("done pulse off Q4");
    write_back_a: assert property (file_wr.wr_en
        |-> $past(instr[7], 4) && file_wr.addr == $past(file_rd_addr))
        else $error("write back wrong");
    dest_acc_a: assert property (instr_done && !$past(instr[7], 4) && $past(instr[13:12], 4) == 2'h0
        |-> !file_wr.wr_en)
        else $error("register written with dest clear");
    squash_len_a: assert property ($rose(skip_active) |-> squash_cycle)
        else $error("squash length wrong");
    skip_flags_a: assert property ($rose(skip_active) |-> instr_done && $stable(zero_flag))
        else $error("skip changed flag");
    inc_zero_a: assert property (instr_done && $past(instr[13:8], 4) == `IOX_OPC_INC_FILE
        |-> zero_flag == ($past(file_rd_data, 3) == 8'hFF))
        else $error("increment zero flag wrong");
    or_lit_a: assert property (instr_done && !$past(skip_active) && $past(instr[13:8], 4) == `IOX_OPC_OR_LIT
        |-> acc == ($past(acc) | $past(instr[7:0], 4)))
        else $error("literal or wrong");
    no_skip_a: assert property (instr_done && $past(instr[13:8], 4) == `IOX_OPC_INC_SKIP
        && $past(file_rd_data, 3) != 8'hFF |-> !skip_active)
        else $error("skip on nonzero");
    rd_addr_a: assert property (phase == iox_pkg::IOX_Q2 && !skip_active
        |-> file_rd_addr == $past(instr[6:0]))
        else $error("read address wrong");
endmodule // iox_exec_assertions

bind iox_exec iox_exec_assertions u_chk (.clk(clk), .rst_n(rst_n), .instr(instr), .file_rd_data(file_rd_data),
    .phase(phase), .file_rd_addr(file_rd_addr), .file_wr(file_wr), .acc(acc), .zero_flag(zero_flag),
    .skip_active(skip_active), .instr_done(instr_done));

// *** dv/increment_and_or_instruction_exec_tb.sv ***
// Purpose: Self-checking bench for iox_exec
// Assumes: One instruction per four clocks, back to back
// Notes:   Reference model tracks accumulator and zero flag
`timescale 1ns/10ps
`include "iox_defines.svh"
module increment_and_or_instruction_exec_tb;
    typedef struct packed {
        iox_pkg::iox_file_wr_s w;
        logic [7:0]            ac;
        logic                  z;
        logic                  sk;
    } iox_exp_s;
    logic                  clk, rst_n, zero_flag, skip_active, instr_done, z_m, last_skip;
    logic [13:0]           instr, ins;
    logic [7:0]            file_rd_data, acc, acc_m, d;
    logic [6:0]            file_rd_addr;
    iox_pkg::iox_phase_e   phase;
    iox_pkg::iox_file_wr_s file_wr;
    iox_exp_s              q[$];
    iox_exp_s              e, m;
    logic [5:0]            ops[4] = '{`IOX_OPC_INC_FILE, `IOX_OPC_INC_SKIP, `IOX_OPC_OR_FILE, `IOX_OPC_OR_LIT};
    int                    error_cnt, compares, cyc;
    integer                seed = 32'h8f5ac081;
    logic [31:0]           r;

    iox_exec DUT (.clk(clk), .rst_n(rst_n), .instr(instr), .file_rd_data(file_rd_data), .phase(phase),
        .file_rd_addr(file_rd_addr), .file_wr(file_wr), .acc(acc), .zero_flag(zero_flag),
        .skip_active(skip_active), .instr_done(instr_done));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] got);
        compares++;
        if (got !== ex) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, ex, got);
        end
    endtask

    // Note the expected outcome of one instruction
    task automatic model(input logic [13:0] k, input logic [7:0] fd);
        logic [7:0] res;
        e = '0;
        case (k[13:8])
            `IOX_OPC_OR_LIT: res = acc_m | k[7:0];
            `IOX_OPC_OR_FILE: res = acc_m | fd;
            default: res = fd + 8'h01;
        endcase
        if (k[13:8] != `IOX_OPC_INC_SKIP) z_m = (res == 8'h00);
        else e.sk = (res == 8'h00);
        // Idle write request still shows the word's address and the result
        e.w = {k[7] && k[13:8] != `IOX_OPC_OR_LIT, k[6:0], res};
        if (!e.w.wr_en) acc_m = res;
        e.ac = acc_m;
        e.z = z_m;
        q.push_back(e);
    endtask

    // Present an instruction in the next Q1
    task automatic issue(input logic [13:0] k, input logic [7:0] fd, input bit keep);
        do begin @(posedge clk); #1; end while (phase !== iox_pkg::IOX_Q1);
        instr = k;
        file_rd_data = fd;
        if (keep) model(k, fd);
    endtask

    task automatic results();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, timeout, monitor, stimulus
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc > 1000) begin
            error_cnt++;
            results();
        end
    end

    // Compare results as they appear, ignoring the squashed cycle
    always @(negedge clk) begin
        if (rst_n === 1'b1) begin
            if (instr_done === 1'b1 && last_skip !== 1'b1 && q.size() > 0) begin
                m = q.pop_front();
                chk("file_wr", m.w, file_wr);
                chk("acc", m.ac, acc);
                chk("zero_flag", m.z, zero_flag);
                chk("skip_active", m.sk, skip_active);
            end
            last_skip = skip_active;
        end
    end

    // Boundary data first, then random operands
    initial begin
        rst_n = 1'b0;
        last_skip = 1'b0;
        acc_m = 8'h00;
        z_m = 1'b0;
        instr = 14'h3800;
        file_rd_data = 8'h00;
        model(14'h3800, 8'h00);
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 28; i++) begin
            r = $random(seed);
            d = (i < 8) ? {8{~i[2]}} : r[15:8];
            ins = {ops[i % 4], i < 8 ? i[0] ^ i[1] : r[7], r[6:0]};
            issue(ins, d, 1'b1);
            if (e.sk) issue(14'h38FF, 8'h00, 1'b0);
        end
        repeat (8) @(posedge clk);
        chk("pending", 16'h0000, 16'(q.size()));
        results();
    end
endmodule // increment_and_or_instruction_exec_tb
